// >>> doag_pkg.sv
// Package for the data operand address generator.
// Assumes one core clock and a synchronous active-high reset.

package doag_pkg;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DOAG_AW = 14;                  // Linear data address width
   localparam int DOAG_DW = 8;                   // Data byte width
   localparam int DOAG_PW = 20;                  // Program address width
   localparam int DOAG_NPTR = 3;                 // Number of pointer pairs

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   // Plain operand of pointer one; each pair's group sits 8 below the last
   localparam logic [13:0] DOAG_PTR1_PLAIN_ADDR = 14'h3fe7;
   localparam logic [13:0] DOAG_PTR_STRIDE = 14'h0008;
   localparam logic [13:0] DOAG_PTR0_PLAIN_ADDR = DOAG_PTR1_PLAIN_ADDR + DOAG_PTR_STRIDE;
   localparam logic [13:0] DOAG_GROUP_SPAN = 14'h0006;      // Last member offset
   // Access bank: literals at or above this go to the top of the space
   localparam logic [7:0] DOAG_ACC_SPLIT = 8'h60;
   localparam logic [5:0] DOAG_ACC_TOP_BANK = 6'h3f;
   localparam logic [5:0] DOAG_ACC_LOW_BANK = 6'h00;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic [13:0] DOAG_PTR_RST = 14'h0000;
   localparam logic [7:0] DOAG_VIRT_READ = 8'h00;    // Read of a virtual operand

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      DOAG_INHERENT,
      DOAG_PROGRAM,
      DOAG_DIRECT,
      DOAG_LONG
   } doag_kind_e;

   // Member of a pointer group, by offset below the plain operand
   typedef enum logic [2:0] {
      DOAG_OP_PLAIN,
      DOAG_OP_USE_THEN_INCREMENT_OPERAND,
      DOAG_OP_USE_THEN_DECREMENT_OPERAND,
      DOAG_OP_INCREMENT_THEN_USE_OPERAND,
      DOAG_OP_WOFF,
      DOAG_OP_HIGH,
      DOAG_OP_LOW
   } doag_op_e;

   typedef struct packed {
      doag_kind_e kind;
      logic [7:0] literal;        // File address literal
      logic access_sel;           // 1 banked, 0 access bank
      logic [5:0] bank_select_value;
      logic [13:0] long_addr;     // Full address of a long move
      logic wr;                   // 1 write, 0 read
      logic has_dest;             // Instruction carries a destination bit
      logic dest;                 // Destination bit
      logic dest_implicit_w;      // Implicit target is W
      logic [7:0] wdata;
      logic [7:0] wreg;           // Working register value
      logic [19:0] prog_lit;      // Program memory address literal
   } doag_req_s;

   typedef struct packed {
      logic [13:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } doag_mem_s;

endpackage

// >>> doag_core.sv
// Data operand address generator: direct, access-bank, long and indirect
// addressing with three pointer pairs and their virtual operands.
// Assumes a data RAM with combinational read that answers in the cycle
// its strobe is shown, and a decoder issuing at most one request a cycle.
//
// How it works
// [R1] Direct ops carry 8-bit file literal
// [R2] Banked: bank value joins literal, 14 bits
// [R3] Access bank ignores bank select value
// [R4] Literal 60h-FFh maps 3F60h-3FFFh; rest bank0
// [R5] Long move uses whole opcode address
// [R6] Destination bit picks source register or W
// [R7] Three 14-bit pointer pairs, high/low bytes
// [R8] Plain operand uses pointer, leaves it
// [R9] Indirect target depends on pointer only, plus W for W-offset
// [R10] Use-then-decrement: access, then pointer minus one
// [R11] Use-then-increment: access, then pointer plus one
// [R12] Increment-then-use: pointer plus one, then access
// [R13] W-offset: pointer plus signed W, nothing changes
// [R14] Step carries across whole pointer pair
// [R15] Pointer steps touch no status flags
// [R16] Indirect to virtual operand: read 00h, write nothing
// [R17] Indirect write to pointer: no step of the written pair
// [R18] Pointer bytes readable, writable by direct ops
// [R19] Indirect reaches all other special registers
// [R20] Jumps carry 20-bit program address literal
// [R21] Bank value is upper six address bits
// [R22] Wrap modulo 14 bits; unused high bits zero

`timescale 1ns/100ps
`default_nettype none

module doag_core
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_REQ_VALID,
   input wire doag_pkg::doag_req_s I_REQ,
   output doag_pkg::doag_mem_s O_MEM,
   input wire logic [7:0] I_MEM_RDATA,
   output logic O_RD_VALID,
   output logic [7:0] O_RD_DATA,
   output logic O_RES_TO_W,
   output logic O_PROG_VALID,
   output logic [19:0] O_PROG_ADDR
);
   import doag_pkg::*;

   // ----------------------------------------------------------------
   // Group decode
   // ----------------------------------------------------------------

   typedef struct packed {
      logic hit;                  // Address is a pointer group member
      logic [1:0] idx;            // Which pointer pair
      doag_op_e op;               // Which member
   } doag_hit_s;

   // Find whether an address lands in one of the pointer groups
   function automatic doag_hit_s doag_decode(input logic [13:0] a);
      doag_hit_s r;
      logic [13:0] base;
      logic [13:0] off;
      r = '0;
      for (int n = 0; n < DOAG_NPTR; n++)
      begin
         base = DOAG_PTR0_PLAIN_ADDR - DOAG_PTR_STRIDE * 14'(n);
         off = base - a;
         if (a <= base && off <= DOAG_GROUP_SPAN)
         begin
            r.hit = 1'b1;
            r.idx = 2'(n);
            r.op = doag_op_e'(off[2:0]);
         end
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------

   logic [13:0] ptr_ff [DOAG_NPTR];      // Pointer pairs, 14 bits each
   logic [13:0] nxt_ptr [DOAG_NPTR];
   doag_mem_s mem_ff;                     // Memory strobe stage
   doag_mem_s nxt_mem;
   logic rd_pend_ff;                      // A read answers next cycle
   logic nxt_rd_pend;
   logic rd_from_mem_ff;                  // Answer comes from RAM
   logic nxt_rd_from_mem;
   logic [7:0] rd_local_ff;               // Answer held locally
   logic [7:0] nxt_rd_local;
   logic res_w_ff;                        // Result destination, staged
   logic nxt_res_w;
   logic rd_valid_ff;
   logic [7:0] rd_data_ff;
   logic res_to_w_ff;
   logic prog_valid_ff;
   logic [19:0] prog_addr_ff;

   // ----------------------------------------------------------------
   // Operand address resolution
   // ----------------------------------------------------------------

   logic [13:0] eff_addr;                 // Address named by the instruction
   logic addr_access;                     // Request touches data space
   doag_hit_s eff_hit;                    // Instruction names a group member
   logic [13:0] sel_ptr;                  // Pointer of the named group
   logic [13:0] ind_addr;                 // Indirect target
   doag_hit_s ind_hit;                    // Indirect target is a group member

   // Form the data address of a direct or long request
   always_comb
   begin
      eff_addr = '0;
      addr_access = 1'b0;
      if (I_REQ_VALID)
      begin
         case (I_REQ.kind)
            DOAG_DIRECT:
            begin
               addr_access = 1'b1;                                      // [R1]
               if (I_REQ.access_sel)
                  eff_addr = {I_REQ.bank_select_value, I_REQ.literal};  // [R2] [R21]
               else if (I_REQ.literal >= DOAG_ACC_SPLIT)
                  eff_addr = {DOAG_ACC_TOP_BANK, I_REQ.literal};        // [R3] [R4]
               else
                  eff_addr = {DOAG_ACC_LOW_BANK, I_REQ.literal};        // [R4]
            end
            DOAG_LONG:
            begin
               addr_access = 1'b1;
               eff_addr = I_REQ.long_addr;                              // [R5]
            end
            DOAG_INHERENT, DOAG_PROGRAM:
               addr_access = 1'b0;
            default:
               addr_access = 1'b0;
         endcase
      end
   end

   // Indirect target comes from the pointer, plus W for the W-offset member, never the bank value
   always_comb
   begin
      eff_hit = doag_decode(eff_addr);
      sel_ptr = ptr_ff[eff_hit.idx];
      case (eff_hit.op)
         DOAG_OP_INCREMENT_THEN_USE_OPERAND:
            ind_addr = sel_ptr + 14'h0001;                              // [R12] [R22]
         DOAG_OP_WOFF:
            ind_addr = sel_ptr + {{6{I_REQ.wreg[7]}}, I_REQ.wreg};      // [R13] [R22]
         default:
            ind_addr = sel_ptr;                                         // [R8] [R9]
      endcase
      ind_hit = doag_decode(ind_addr);
   end

   // ----------------------------------------------------------------
   // Access steering and pointer update
   // ----------------------------------------------------------------

   logic is_ind;                          // Named member is a virtual operand
   logic [13:0] step_val;                 // Stepped pointer of the named group
   logic step_en;

   // Decide where the access goes and what it does to the pointers.
   // Pointer steps feed nothing but the pointer itself, so no status flag
   // can ever see them.
   always_comb
   begin
      for (int n = 0; n < DOAG_NPTR; n++)
         nxt_ptr[n] = ptr_ff[n];
      nxt_mem = '0;
      nxt_rd_pend = 1'b0;
      nxt_rd_from_mem = 1'b0;
      nxt_rd_local = DOAG_VIRT_READ;
      is_ind = addr_access && eff_hit.hit && eff_hit.op <= DOAG_OP_WOFF;
      step_en = 1'b0;
      step_val = sel_ptr;
      case (eff_hit.op)
         DOAG_OP_USE_THEN_INCREMENT_OPERAND:
         begin
            step_en = 1'b1;
            step_val = sel_ptr + 14'h0001;                              // [R11] [R14] [R15]
         end
         DOAG_OP_USE_THEN_DECREMENT_OPERAND:
         begin
            step_en = 1'b1;
            step_val = sel_ptr - 14'h0001;                              // [R10] [R14] [R15]
         end
         DOAG_OP_INCREMENT_THEN_USE_OPERAND:
         begin
            step_en = 1'b1;
            step_val = sel_ptr + 14'h0001;                              // [R12] [R14]
         end
         default:
            step_en = 1'b0;                                             // [R8] [R13]
      endcase
      if (addr_access)
      begin
         nxt_rd_pend = !I_REQ.wr;
         if (is_ind)
         begin
            // Side effect of the named group, unless overwritten below
            if (step_en)
               nxt_ptr[eff_hit.idx] = step_val;
            if (ind_hit.hit && ind_hit.op <= DOAG_OP_WOFF)
            begin
               // Virtual through virtual: reads zero, writes vanish
               nxt_rd_local = DOAG_VIRT_READ;                           // [R16]
            end
            else if (ind_hit.hit)
            begin
               // Pointer byte reached indirectly; a write wins over the step
               if (I_REQ.wr)
               begin
                  if (ind_hit.op == DOAG_OP_HIGH)
                     nxt_ptr[ind_hit.idx] = {I_REQ.wdata[5:0],
                                             ptr_ff[ind_hit.idx][7:0]}; // [R17]
                  else
                     nxt_ptr[ind_hit.idx] = {ptr_ff[ind_hit.idx][13:8],
                                             I_REQ.wdata};              // [R17]
               end
               else if (ind_hit.op == DOAG_OP_HIGH)
                  nxt_rd_local = {2'b00, ptr_ff[ind_hit.idx][13:8]};    // [R22]
               else
                  nxt_rd_local = ptr_ff[ind_hit.idx][7:0];
            end
            else
            begin
               // Any other location, special registers included
               nxt_mem.addr = ind_addr;                                 // [R19]
               nxt_mem.rd = !I_REQ.wr;
               nxt_mem.wr = I_REQ.wr;
               nxt_mem.wdata = I_REQ.wdata;
               nxt_rd_from_mem = 1'b1;
            end
         end
         else if (eff_hit.hit)
         begin
            // Pointer bytes are real registers open to direct access
            if (I_REQ.wr)
            begin
               if (eff_hit.op == DOAG_OP_HIGH)
                  nxt_ptr[eff_hit.idx] = {I_REQ.wdata[5:0], sel_ptr[7:0]};  // [R18] [R7]
               else
                  nxt_ptr[eff_hit.idx] = {sel_ptr[13:8], I_REQ.wdata};      // [R18] [R7]
            end
            else if (eff_hit.op == DOAG_OP_HIGH)
               nxt_rd_local = {2'b00, sel_ptr[13:8]};                   // [R18] [R22]
            else
               nxt_rd_local = sel_ptr[7:0];                             // [R18]
         end
         else
         begin
            // Plain RAM or special register addressed directly
            nxt_mem.addr = eff_addr;
            nxt_mem.rd = !I_REQ.wr;
            nxt_mem.wr = I_REQ.wr;
            nxt_mem.wdata = I_REQ.wdata;
            nxt_rd_from_mem = 1'b1;
         end
      end
   end

   // Result destination: explicit bit, else the implicit target
   always_comb
   begin
      if (I_REQ.has_dest)
         nxt_res_w = !I_REQ.dest;                                       // [R6]
      else
         nxt_res_w = I_REQ.dest_implicit_w;                             // [R6]
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   // Pointer pairs; top two bits of each high byte are never stored
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         for (int n = 0; n < DOAG_NPTR; n++)
            ptr_ff[n] <= DOAG_PTR_RST;
      end
      else
      begin
         for (int n = 0; n < DOAG_NPTR; n++)
            ptr_ff[n] <= nxt_ptr[n];                                    // [R7] [R14]
      end
   end

   // Memory strobe stage, one cycle after the request
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         mem_ff <= '0;
         rd_pend_ff <= 1'b0;
         rd_from_mem_ff <= 1'b0;
         rd_local_ff <= DOAG_VIRT_READ;
         res_w_ff <= 1'b0;
      end
      else
      begin
         mem_ff <= nxt_mem;
         rd_pend_ff <= nxt_rd_pend;
         rd_from_mem_ff <= nxt_rd_from_mem;
         rd_local_ff <= nxt_rd_local;
         res_w_ff <= nxt_res_w;
      end
   end

   // Read answer stage; RAM data is caught while its strobe stands
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         rd_valid_ff <= 1'b0;
         rd_data_ff <= '0;
         res_to_w_ff <= 1'b0;
      end
      else
      begin
         rd_valid_ff <= rd_pend_ff;
         res_to_w_ff <= rd_pend_ff & res_w_ff;
         if (rd_pend_ff)
            rd_data_ff <= rd_from_mem_ff ? I_MEM_RDATA : rd_local_ff;
      end
   end

   // Program address literal of jumps and calls; inherent requests
   // produce no address of any kind
   always_ff @(posedge I_CLK)
   begin
      if (I_RST)
      begin
         prog_valid_ff <= 1'b0;
         prog_addr_ff <= '0;
      end
      else
      begin
         prog_valid_ff <= I_REQ_VALID && I_REQ.kind == DOAG_PROGRAM;    // [R20]
         if (I_REQ_VALID && I_REQ.kind == DOAG_PROGRAM)
            prog_addr_ff <= I_REQ.prog_lit;                             // [R20]
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   assign O_MEM = mem_ff;
   assign O_RD_VALID = rd_valid_ff;
   assign O_RD_DATA = rd_data_ff;
   assign O_RES_TO_W = res_to_w_ff;
   assign O_PROG_VALID = prog_valid_ff;
   assign O_PROG_ADDR = prog_addr_ff;

endmodule

`default_nettype wire

// >>> doag_core_assertions.sv
// Concurrent checks on the ports of the operand address generator.
// Assumes one core clock and the synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
module doag_chk
(
   input wire logic I_CLK,
   input wire logic I_RST,
   input wire logic I_REQ_VALID,
   input wire doag_pkg::doag_req_s I_REQ,
   input wire doag_pkg::doag_mem_s O_MEM,
   input wire logic [7:0] I_MEM_RDATA,
   input wire logic O_RD_VALID,
   input wire logic [7:0] O_RD_DATA,
   input wire logic O_RES_TO_W,
   input wire logic O_PROG_VALID,
   input wire logic [19:0] O_PROG_ADDR
);
   import doag_pkg::*;
   // -----------------------------------------------------------
   // Timing and mapping
   // -----------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (I_RST);
   // Banked address below the pointer space goes straight out
   banked_addr_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_DIRECT && I_REQ.access_sel
      && I_REQ.bank_select_value != 6'h3f
      |=> (O_MEM.rd || O_MEM.wr)
      && O_MEM.addr == {$past(I_REQ.bank_select_value), $past(I_REQ.literal)})
      else $error("banked address wrong");
   access_low_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_DIRECT && !I_REQ.access_sel
      && I_REQ.literal < 8'h60
      |=> O_MEM.addr == {6'h00, $past(I_REQ.literal)})
      else $error("low access bank address wrong");
   // Upper limit keeps clear of the pointer groups, which are answered locally or redirected through a pointer
   access_top_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_DIRECT && !I_REQ.access_sel
      && I_REQ.literal >= 8'h60 && I_REQ.literal < 8'hd9
      |=> O_MEM.addr == {6'h3f, $past(I_REQ.literal)})
      else $error("top access bank address wrong");
   // A long move into the pointer groups is answered locally or redirected through a pointer
   long_addr_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_LONG && I_REQ.long_addr < 14'h3fd9
      |=> (O_MEM.rd || O_MEM.wr) && O_MEM.addr == $past(I_REQ.long_addr))
      else $error("long move address wrong");
   read_answer_a: assert property (
      I_REQ_VALID && !I_REQ.wr
      && (I_REQ.kind == DOAG_DIRECT || I_REQ.kind == DOAG_LONG) |-> ##2 O_RD_VALID)
      else $error("read answer missing");
   dest_sel_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_DIRECT && !I_REQ.wr && I_REQ.has_dest
      |-> ##2 O_RES_TO_W == !$past(I_REQ.dest, 2))
      else $error("result target wrong");
   prog_lit_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_PROGRAM
      |=> O_PROG_VALID && O_PROG_ADDR == $past(I_REQ.prog_lit))
      else $error("program literal wrong");
   inherent_quiet_a: assert property (
      I_REQ_VALID && I_REQ.kind == DOAG_INHERENT
      |=> !O_MEM.rd && !O_MEM.wr && !O_PROG_VALID)
      else $error("inherent op made an access");
   idle_strobe_a: assert property (!$past(I_REQ_VALID) |-> !O_MEM.rd && !O_MEM.wr)
      else $error("strobe without request");
endmodule
bind doag_core doag_chk u_doag_chk (.I_CLK(I_CLK), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID),
   .I_REQ(I_REQ), .O_MEM(O_MEM), .I_MEM_RDATA(I_MEM_RDATA), .O_RD_VALID(O_RD_VALID),
   .O_RD_DATA(O_RD_DATA), .O_RES_TO_W(O_RES_TO_W), .O_PROG_VALID(O_PROG_VALID),
   .O_PROG_ADDR(O_PROG_ADDR));
`default_nettype wire

// >>> doag_ram_model.sv
// Data RAM model on the far side of the address generator.
// Assumes strobes last one core cycle; reads answer combinationally.
`timescale 1ns/100ps
`default_nettype none
module doag_ram_model
(
   input wire logic i_clk,
   input wire doag_pkg::doag_mem_s i_mem,
   output logic [7:0] o_rdata
);
   import doag_pkg::*;
   // -----------------------------------------------------------
   // Storage
   // -----------------------------------------------------------
   logic [7:0] mem [0:16383]; // Preset to an address pattern
   logic [7:0] last_ff;        // Last byte shown on a read
   initial
   begin
      for (int a = 0; a < 16384; a++)
         mem[a] = 8'(a) ^ {2'b00, 6'(a >> 8)};
      last_ff = 8'h00;
   end
   // Write on strobe; remember the last read byte
   always @(posedge i_clk)
   begin
      if (i_mem.wr)
         mem[i_mem.addr] <= i_mem.wdata;
      if (i_mem.rd)
         last_ff <= o_rdata;
   end
   // Off strobe the data shows the inverse, so a stale copy never matches
   always_comb
      o_rdata = i_mem.rd ? mem[i_mem.addr] : ~last_ff;
endmodule
`default_nettype wire

// >>> test_data_operand_address_gen.sv
// Testbench for the operand address generator: tables of accesses.
// Assumes the RAM model presets each byte to a pattern of its address.
`timescale 1ns/100ps
`default_nettype none
module test_data_operand_address_gen;
   import doag_pkg::*;
   logic I_CLK, I_RST, I_REQ_VALID, O_RD_VALID, O_RES_TO_W, O_PROG_VALID;
   doag_req_s I_REQ, rq;
   doag_mem_s O_MEM;
   logic [7:0] I_MEM_RDATA, O_RD_DATA, wv;
   logic [19:0] O_PROG_ADDR;
   logic [7:0] lits [3] = '{8'h5f, 8'h60, 8'hff};
   logic [13:0] ea;
   int error_cnt = 0;
   int n_checks = 0;
   doag_core u_doag_core (.I_CLK(I_CLK), .I_RST(I_RST), .I_REQ_VALID(I_REQ_VALID), .I_REQ(I_REQ),
      .O_MEM(O_MEM), .I_MEM_RDATA(I_MEM_RDATA), .O_RD_VALID(O_RD_VALID), .O_RD_DATA(O_RD_DATA),
      .O_RES_TO_W(O_RES_TO_W), .O_PROG_VALID(O_PROG_VALID), .O_PROG_ADDR(O_PROG_ADDR));
   doag_ram_model u_doag_ram_model (.i_clk(I_CLK), .i_mem(O_MEM), .o_rdata(I_MEM_RDATA));
   initial
   begin
      I_CLK = 1'b0;
      forever #12.5 I_CLK = ~I_CLK;
   end
   // -----------------------------------------------------------
   // Helpers
   // -----------------------------------------------------------
   function automatic logic [7:0] pat(input logic [13:0] a);
      return a[7:0] ^ {2'b00, a[13:8]};
   endfunction
   task automatic chk(input string nm, input logic [19:0] seen, input logic [19:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Issue rq, then look at the strobe in cycle 1 and the answer in cycle 2
   task automatic go(input logic [13:0] ea, input logic st, input logic [7:0] ed);
      logic rdv;
      rdv = !rq.wr && (rq.kind == DOAG_DIRECT || rq.kind == DOAG_LONG);
      @(negedge I_CLK);
      I_REQ = rq;
      I_REQ_VALID = 1'b1;
      @(negedge I_CLK);
      I_REQ_VALID = 1'b0;
      chk("strobe", {O_MEM.rd, O_MEM.wr}, st ? {!rq.wr, rq.wr} : 2'b00);
      if (st)
         chk("addr", O_MEM.addr, ea);
      if (st && rq.wr)
         chk("wdata", O_MEM.wdata, rq.wdata);
      chk("prog valid", O_PROG_VALID, rq.kind == DOAG_PROGRAM);
      if (rq.kind == DOAG_PROGRAM)
         chk("prog addr", O_PROG_ADDR, rq.prog_lit);
      @(negedge I_CLK);
      chk("rd valid", O_RD_VALID, rdv);
      if (rdv)
         chk("rd data", O_RD_DATA, ed);
      // Pulses with a read answer only; implicit target when no bit is given
      chk("to w", O_RES_TO_W, rdv && (rq.has_dest ? !rq.dest : rq.dest_implicit_w));
   endtask
   // Banked access to any address: bank value on top, literal below
   task automatic acc(input logic [13:0] ad, input logic wr, input logic [7:0] wd,
      input logic [13:0] ea, input logic st, input logic [7:0] ed);
      rq = '0;
      rq.kind = DOAG_DIRECT;
      rq.access_sel = 1'b1;
      {rq.bank_select_value, rq.literal} = ad;
      rq.wr = wr;
      rq.wdata = wd;
      rq.has_dest = 1'b1;
      rq.dest = ad[0];
      rq.wreg = wv;
      go(ea, st, ed);
   endtask
   // Watchdog: a hang counts as a mismatch
   initial
   begin
      repeat (5000) @(posedge I_CLK);
      error_cnt++;
      $display("unexpected run length: expected end seen hang");
      close_out();
   end
   // -----------------------------------------------------------
   // Main sequence
   // -----------------------------------------------------------
   initial
   begin
      I_RST = 1'b1;
      I_REQ_VALID = 1'b0;
      I_REQ = '0;
      rq = '0;
      wv = 8'h00;
      // Count rising edges: the clock's first step from unknown is no edge
      repeat (5) @(posedge I_CLK);
      @(negedge I_CLK);
      chk("reset outs", {O_MEM.rd, O_MEM.wr, O_RD_VALID, O_PROG_VALID, O_RES_TO_W}, 5'h00);
      chk("reset data", O_RD_DATA, 8'h00);
      chk("reset prog", O_PROG_ADDR, 20'h00000);
      I_RST = 1'b0;
      acc(14'h020a, 0, 8'h00, 14'h020a, 1, pat(14'h020a));
      acc(14'h1355, 1, 8'h3c, 14'h1355, 1, 8'h00);
      acc(14'h1355, 0, 8'h00, 14'h1355, 1, 8'h3c);
      foreach (lits[i])
      begin
         rq = '0;
         rq.kind = DOAG_DIRECT;
         rq.literal = lits[i];
         rq.bank_select_value = 6'h15;
         rq.dest_implicit_w = lits[i][0];
         ea = {(lits[i] < 8'h60) ? 6'h00 : 6'h3f, lits[i]};
         go(ea, 1, pat(ea));
      end
      rq = '0;
      rq.kind = DOAG_LONG;
      rq.long_addr = 14'h2abc;
      rq.bank_select_value = 6'h01;
      go(14'h2abc, 1, pat(14'h2abc));
      rq.kind = DOAG_PROGRAM;
      rq.prog_lit = 20'habcde;
      go(14'h0000, 0, 8'h00);
      rq.kind = DOAG_INHERENT;
      go(14'h0000, 0, 8'h00);
      $display("test direct done");
      acc(14'h3fea, 1, 8'hff, 14'h0, 0, 8'h00);
      acc(14'h3fea, 0, 8'h00, 14'h0, 0, 8'h3f);
      acc(14'h3fea, 1, 8'h01, 14'h0, 0, 8'h00);
      acc(14'h3fe9, 1, 8'hff, 14'h0, 0, 8'h00);
      acc(14'h3fef, 0, 8'h00, 14'h01ff, 1, pat(14'h01ff));
      acc(14'h3fee, 0, 8'h00, 14'h01ff, 1, pat(14'h01ff));
      acc(14'h3fe9, 0, 8'h00, 14'h0, 0, 8'h00);
      acc(14'h3fea, 0, 8'h00, 14'h0, 0, 8'h02);
      acc(14'h3fed, 0, 8'h00, 14'h0200, 1, pat(14'h0200));
      acc(14'h3fef, 0, 8'h00, 14'h01ff, 1, pat(14'h01ff));
      acc(14'h3fec, 0, 8'h00, 14'h0200, 1, pat(14'h0200));
      wv = 8'hff;
      acc(14'h3feb, 0, 8'h00, 14'h01ff, 1, pat(14'h01ff));
      wv = 8'h80;
      acc(14'h3feb, 0, 8'h00, 14'h0180, 1, pat(14'h0180));
      wv = 8'h7f;
      acc(14'h3feb, 0, 8'h00, 14'h027f, 1, pat(14'h027f));
      acc(14'h3fef, 0, 8'h00, 14'h0200, 1, pat(14'h0200));
      acc(14'h3fea, 1, 8'h3f, 14'h0, 0, 8'h00);
      acc(14'h3fe9, 1, 8'hff, 14'h0, 0, 8'h00);
      acc(14'h3fee, 0, 8'h00, 14'h3fff, 1, pat(14'h3fff));
      acc(14'h3fef, 1, 8'ha7, 14'h0000, 1, 8'h00);
      acc(14'h0000, 0, 8'h00, 14'h0000, 1, 8'ha7);
      $display("test pointer steps done");
      acc(14'h3fe2, 1, 8'h01, 14'h0, 0, 8'h00);
      acc(14'h3fe1, 1, 8'h23, 14'h0, 0, 8'h00);
      acc(14'h3fe7, 0, 8'h00, 14'h0123, 1, pat(14'h0123));
      // Pointer zero wrapped to 0000 above; aim it at pointer one's plain operand
      acc(14'h3fea, 1, 8'h3f, 14'h0, 0, 8'h00);
      acc(14'h3fe9, 1, 8'he7, 14'h0, 0, 8'h00);
      acc(14'h3fef, 0, 8'h00, 14'h0, 0, 8'h00);
      acc(14'h3fef, 1, 8'h55, 14'h0, 0, 8'h00);
      acc(14'h3fe7, 0, 8'h00, 14'h0123, 1, pat(14'h0123));
      acc(14'h3fd9, 1, 8'hd9, 14'h0, 0, 8'h00);
      acc(14'h3fda, 1, 8'h3f, 14'h0, 0, 8'h00);
      acc(14'h3fdd, 1, 8'h40, 14'h0, 0, 8'h00);
      acc(14'h3fd9, 0, 8'h00, 14'h0, 0, 8'h40);
      acc(14'h3fdf, 0, 8'h00, 14'h3f40, 1, pat(14'h3f40));
      $display("test virtual targets done");
      close_out();
   end
endmodule
`default_nettype wire
